/* File: hdl/asem_cfg.svh */
`ifndef ASEM_CFG_SVH
`define ASEM_CFG_SVH

// Register offsets
`define ASEM_ADDR_STATUS 8'h01
`define ASEM_ADDR_MAG 8'h06
`define ASEM_ADDR_ROUTE 8'h07
`define ASEM_ADDR_BIAS 8'h08
`define ASEM_ADDR_MON 8'h09

// Reset values
`define ASEM_RST_MAG 8'h00
`define ASEM_RST_ROUTE 8'h00
`define ASEM_RST_BIAS 8'h00
`define ASEM_RST_MON 8'h00

// Field positions
`define ASEM_STATUS_POR_BIT 7
`define ASEM_STATUS_RDY_BIT 6
`define ASEM_STATUS_REF_BIT 0
`define ASEM_MON_SEL_HI 7
`define ASEM_MON_SEL_LO 5
`define ASEM_BIAS_PINS 7

// Monitor selector codes
`define ASEM_MON_OFF 3'h0
`define ASEM_MON_MIDSCALE 3'h1
`define ASEM_MON_TEMP 3'h2
`define ASEM_MON_ANALOG 3'h3
`define ASEM_MON_DIGITAL 3'h4
`define ASEM_MON_BO_LOW 3'h5
`define ASEM_MON_BO_MID 3'h6
`define ASEM_MON_BO_HIGH 3'h7

// Gain code for unity
`define ASEM_GAIN_UNITY 3'h0

// Timing
`define ASEM_CLK_PERIOD_NS 100
`define ASEM_STARTUP_NS 2000
`define ASEM_STARTUP_CYCLES ((`ASEM_STARTUP_NS + `ASEM_CLK_PERIOD_NS - 1) / `ASEM_CLK_PERIOD_NS)

`endif

/* File: hdl/asem_pkg.sv */
`default_nettype none

package asem_pkg;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b01,
    ST_READY = 2'b10
  } asem_start_state_type;

  typedef enum logic [1:0] {
    BO_OFF = 2'h0,
    BO_0U2 = 2'h1,
    BO_1U = 2'h2,
    BO_10U = 2'h3
  } asem_burnout_type;

  typedef logic [7:0] asem_byte_type;
  typedef logic [3:0] asem_nibble_type;

endpackage

`default_nettype wire

/* File: hdl/asem_mon_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface asem_mon_if;
  import asem_pkg::*;
  logic [2:0] monitor_select;
  logic [2:0] gain_code;
  logic [1:0] amplifier_enable_code;
  logic temp_sensor_en;
  logic analog_supply_reading_en;
  logic digital_supply_reading_en;
  logic midscale_force;
  logic inputs_disconnect;
  logic burnout_current_source;
  asem_burnout_type burnout_level;
  logic [2:0] effective_gain;
  logic [1:0] amp_enable_out;

  modport decoder (
    input monitor_select, gain_code, amplifier_enable_code,
    output temp_sensor_en, analog_supply_reading_en, digital_supply_reading_en,
    output midscale_force, inputs_disconnect, burnout_current_source,
    output burnout_level, effective_gain, amp_enable_out
  );
  modport ctrl (
    output monitor_select, gain_code, amplifier_enable_code,
    input temp_sensor_en, analog_supply_reading_en, digital_supply_reading_en,
    input midscale_force, inputs_disconnect, burnout_current_source,
    input burnout_level, effective_gain, amp_enable_out
  );
endinterface

`default_nettype wire

/* File: hdl/asem_mon_decode.sv */
`timescale 1ns/1ns
`default_nettype none
`include "asem_cfg.svh"

module asem_mon_decode (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Monitor signals
  asem_mon_if.decoder mon
);
  import asem_pkg::*;

  function automatic logic is_supply(input logic [2:0] sel);
    is_supply = (sel == `ASEM_MON_ANALOG) || (sel == `ASEM_MON_DIGITAL);
  endfunction

  // Function enables, registered
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mon.temp_sensor_en <= 1'b0;
      mon.analog_supply_reading_en <= 1'b0;
      mon.digital_supply_reading_en <= 1'b0;
      mon.midscale_force <= 1'b0;
      mon.inputs_disconnect <= 1'b0;
    end else begin
      mon.temp_sensor_en <= (mon.monitor_select == `ASEM_MON_TEMP);
      mon.analog_supply_reading_en <= (mon.monitor_select == `ASEM_MON_ANALOG);
      mon.digital_supply_reading_en <= (mon.monitor_select == `ASEM_MON_DIGITAL);
      mon.midscale_force <= (mon.monitor_select == `ASEM_MON_MIDSCALE);
      // Off and burn-out keep the multiplexed inputs
      mon.inputs_disconnect <= (mon.monitor_select == `ASEM_MON_TEMP) ||
                               is_supply(mon.monitor_select);
    end
  end

  // Burn-out sources on the selected input pair
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mon.burnout_current_source <= 1'b0;
      mon.burnout_level <= BO_OFF;
    end else begin
      mon.burnout_current_source <= mon.monitor_select[2] && (mon.monitor_select[1:0] != 2'h0);
      case (mon.monitor_select)
        `ASEM_MON_BO_LOW: begin
          mon.burnout_level <= BO_0U2;
        end
        `ASEM_MON_BO_MID: begin
          mon.burnout_level <= BO_1U;
        end
        `ASEM_MON_BO_HIGH: begin
          mon.burnout_level <= BO_10U;
        end
        default: begin
          mon.burnout_level <= BO_OFF;
        end
      endcase
    end
  end

  // Gain seen by the amplifier
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mon.effective_gain <= `ASEM_GAIN_UNITY;
      mon.amp_enable_out <= 2'h0;
    end else begin
      mon.amp_enable_out <= mon.amplifier_enable_code;
      if (is_supply(mon.monitor_select)) begin
        mon.effective_gain <= `ASEM_GAIN_UNITY;
      end else begin
        mon.effective_gain <= mon.gain_code;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  AST_SUPPLY_UNITY: assert property (is_supply(mon.monitor_select) |=>
    (mon.effective_gain == `ASEM_GAIN_UNITY) && mon.inputs_disconnect)
    else $error("supply monitor gain not unity");
  AST_TEMP_ROUTE: assert property ((mon.monitor_select == `ASEM_MON_TEMP) |=>
    mon.temp_sensor_en && mon.inputs_disconnect && (mon.effective_gain == $past(mon.gain_code)))
    else $error("temperature mode routing wrong");
  AST_BURNOUT: assert property ((mon.monitor_select == `ASEM_MON_BO_MID) |=>
    mon.burnout_current_source && (mon.burnout_level == BO_1U) && !mon.inputs_disconnect)
    else $error("burn-out level wrong");
  AST_MON_OFF: assert property ((mon.monitor_select == `ASEM_MON_OFF) |=>
    !mon.inputs_disconnect && !mon.burnout_current_source && !mon.midscale_force &&
    !mon.temp_sensor_en)
    else $error("monitor not off");
  AST_AMP_PASS: assert property (1'b1 |=> mon.amp_enable_out == $past(mon.amplifier_enable_code))
    else $error("amplifier enable not passed");

  CV_TEMP: cover property (mon.temp_sensor_en);
  CV_DIGMON: cover property (mon.digital_supply_reading_en);
endmodule

`default_nettype wire

/* File: hdl/asem_ctrl.sv */
// Overview of operation
// - Magnitude code sets both excitation currents
// - Each source routed by own nibble
// - Both sources may share one pin
// - Per-pin enables for mid-supply bias
// - Three-bit monitor selector in 09h
// - Selector 010 routes temperature sensor
// - Temperature mode disconnects inputs, keeps gain
// - Selectors 011/100 route supply readings
// - Supply monitor forces unity gain
// - Supply monitor works with amplifier bypassed
// - Selectors 101-111 set burn-out currents
// - Burn-out sources positive, sinks negative
// - Status byte at 01h with flags
// - Power-on flag set by reset, sticky
// - Power-on flag cleared by writing zero
// - Status bit 6 shows ready
// - Low-reference flag updated each conversion end
// - Selector 001 forces mid-scale input
`timescale 1ns/1ns
`default_nettype none
`include "asem_cfg.svh"

module asem_ctrl #(
  parameter int STARTUP_CYCLES = `ASEM_STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port
  input wire asem_pkg::asem_byte_type i_addr,
  input wire asem_pkg::asem_byte_type i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output asem_pkg::asem_byte_type o_rd_data,
  // Core status inputs
  input wire logic i_por_event,
  input wire logic i_ref_monitor_enable,
  input wire logic i_ref_below_threshold,
  input wire logic i_conversion_done_signal,
  input wire logic [2:0] i_gain_code,
  input wire logic [1:0] i_amplifier_enable_code,
  // Excitation sources
  output asem_pkg::asem_nibble_type o_current_magnitude_code,
  output logic o_excitation_active,
  output asem_pkg::asem_nibble_type o_source_one_pin_select,
  output asem_pkg::asem_nibble_type o_source_two_pin_select,
  // Mid-supply bias
  output logic [6:0] o_bias_pin_enable,
  // System monitor
  output logic o_temp_sensor_en,
  output logic o_analog_supply_reading_en,
  output logic o_digital_supply_reading_en,
  output logic o_midscale_force,
  output logic o_inputs_disconnect,
  output logic o_burnout_current_source,
  output asem_pkg::asem_burnout_type o_burnout_level,
  output logic [2:0] o_effective_gain,
  output logic [1:0] o_amplifier_enable_code,
  // Status flags
  output logic o_power_on_reset_flag,
  output logic o_ready,
  output logic o_low_reference_flag
);
  import asem_pkg::*;

  localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);

  asem_start_state_type state;
  logic [15:0] boot_cnt;
  asem_byte_type reg_mag;
  asem_byte_type reg_route;
  asem_byte_type reg_bias;
  asem_byte_type reg_mon;
  logic por_flag;
  logic ref_flag;
  logic ref_hit;
  logic cfg_wr;
  logic por_clear;
  asem_byte_type next_rd_data;
  asem_byte_type status_byte;

  asem_mon_if mon_bus();

  function automatic logic hit(input asem_byte_type a, input asem_byte_type b);
    hit = (a == b);
  endfunction

  assign cfg_wr = i_wr_en && (state == ST_READY);
  assign por_clear = cfg_wr && hit(i_addr, `ASEM_ADDR_STATUS) &&
                     !i_wr_data[`ASEM_STATUS_POR_BIT];

  // Start-up sequencing; registers locked until ready
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_BOOT;
      boot_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_BOOT: begin
          if (boot_cnt == STARTUP_LAST) begin
            state <= ST_READY;
          end else begin
            boot_cnt <= boot_cnt + 16'h0001;
          end
        end
        ST_READY: begin
          state <= ST_READY;
        end
        default: begin
          state <= ST_BOOT;
          boot_cnt <= 16'h0000;
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reg_mag <= `ASEM_RST_MAG;
      reg_route <= `ASEM_RST_ROUTE;
      reg_bias <= `ASEM_RST_BIAS;
      reg_mon <= `ASEM_RST_MON;
    end else if (cfg_wr) begin
      if (hit(i_addr, `ASEM_ADDR_MAG)) begin
        reg_mag <= i_wr_data;
      end
      if (hit(i_addr, `ASEM_ADDR_ROUTE)) begin
        reg_route <= i_wr_data;
      end
      if (hit(i_addr, `ASEM_ADDR_BIAS)) begin
        reg_bias <= i_wr_data;
      end
      if (hit(i_addr, `ASEM_ADDR_MON)) begin
        reg_mon <= i_wr_data;
      end
    end
  end

  // Power-on flag: reset sets it, a fresh event beats the clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      por_flag <= 1'b1;
    end else if (i_por_event) begin
      por_flag <= 1'b1;
    end else if (por_clear) begin
      por_flag <= 1'b0;
    end
  end

  // Low-reference fault caught over the conversion, shown at its end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_hit <= 1'b0;
      ref_flag <= 1'b0;
    end else if (i_conversion_done_signal) begin
      ref_flag <= ref_hit || (i_ref_monitor_enable && i_ref_below_threshold);
      ref_hit <= 1'b0;
    end else if (i_ref_monitor_enable && i_ref_below_threshold) begin
      ref_hit <= 1'b1;
    end
  end

  // Read path
  always_comb begin
    status_byte = 8'h00;
    status_byte[`ASEM_STATUS_POR_BIT] = por_flag;
    status_byte[`ASEM_STATUS_RDY_BIT] = (state == ST_READY);
    status_byte[`ASEM_STATUS_REF_BIT] = ref_flag;
    case (i_addr)
      `ASEM_ADDR_STATUS: begin
        next_rd_data = status_byte;
      end
      `ASEM_ADDR_MAG: begin
        next_rd_data = reg_mag;
      end
      `ASEM_ADDR_ROUTE: begin
        next_rd_data = reg_route;
      end
      `ASEM_ADDR_BIAS: begin
        next_rd_data = reg_bias;
      end
      `ASEM_ADDR_MON: begin
        next_rd_data = reg_mon;
      end
      default: begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      o_rd_data <= next_rd_data;
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // Excitation and bias outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_current_magnitude_code <= 4'h0;
      o_excitation_active <= 1'b0;
      o_source_one_pin_select <= 4'h0;
      o_source_two_pin_select <= 4'h0;
      o_bias_pin_enable <= 7'h00;
    end else begin
      o_current_magnitude_code <= reg_mag[3:0];
      o_excitation_active <= (reg_mag[3:0] != 4'h0);
      // Equal nibbles pass unchanged
      o_source_one_pin_select <= reg_route[3:0];
      o_source_two_pin_select <= reg_route[7:4];
      o_bias_pin_enable <= reg_bias[`ASEM_BIAS_PINS-1:0];
    end
  end

  // Status outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_power_on_reset_flag <= 1'b1;
      o_ready <= 1'b0;
      o_low_reference_flag <= 1'b0;
    end else begin
      o_power_on_reset_flag <= por_flag;
      o_ready <= (state == ST_READY);
      o_low_reference_flag <= ref_flag;
    end
  end

  // Monitor decoder
  assign mon_bus.monitor_select = reg_mon[`ASEM_MON_SEL_HI:`ASEM_MON_SEL_LO];
  assign mon_bus.gain_code = i_gain_code;
  assign mon_bus.amplifier_enable_code = i_amplifier_enable_code;

  asem_mon_decode u_decode (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .mon(mon_bus.decoder)
  );

  assign o_temp_sensor_en = mon_bus.temp_sensor_en;
  assign o_analog_supply_reading_en = mon_bus.analog_supply_reading_en;
  assign o_digital_supply_reading_en = mon_bus.digital_supply_reading_en;
  assign o_midscale_force = mon_bus.midscale_force;
  assign o_inputs_disconnect = mon_bus.inputs_disconnect;
  assign o_burnout_current_source = mon_bus.burnout_current_source;
  assign o_burnout_level = mon_bus.burnout_level;
  assign o_effective_gain = mon_bus.effective_gain;
  assign o_amplifier_enable_code = mon_bus.amp_enable_out;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  AST_POR_SET: assert property (i_por_event |=> por_flag ##1 o_power_on_reset_flag)
    else $error("power-on flag not set");
  AST_POR_STICKY: assert property (por_flag && !por_clear |=> por_flag)
    else $error("power-on flag dropped without clear");
  AST_POR_CLEAR: assert property (por_clear && !i_por_event |=> !por_flag ##1
    !o_power_on_reset_flag)
    else $error("power-on flag clear failed");
  AST_SAME_PIN: assert property (cfg_wr && hit(i_addr, `ASEM_ADDR_ROUTE) |-> ##2
    (o_source_one_pin_select == $past(i_wr_data[3:0], 2)) &&
    (o_source_two_pin_select == $past(i_wr_data[7:4], 2)))
    else $error("routing write not applied");
  AST_MAG_WRITE: assert property (cfg_wr && hit(i_addr, `ASEM_ADDR_MAG) |-> ##2
    o_current_magnitude_code == $past(i_wr_data[3:0], 2))
    else $error("magnitude write not applied");
  AST_BIAS_WRITE: assert property (cfg_wr && hit(i_addr, `ASEM_ADDR_BIAS) |-> ##2
    o_bias_pin_enable == $past(i_wr_data[6:0], 2))
    else $error("bias enable write not applied");
  AST_BOOT_LOCK: assert property ((state == ST_BOOT) && i_wr_en |=>
    $stable(reg_mag) && $stable(reg_route) && $stable(reg_mon) && !o_ready)
    else $error("write taken before ready");
  AST_REF_UPDATE: assert property (i_conversion_done_signal && !ref_hit &&
    !(i_ref_monitor_enable && i_ref_below_threshold) |=> !ref_flag ##1 !o_low_reference_flag)
    else $error("low-reference flag not refreshed");
  AST_REF_HOLD: assert property (!i_conversion_done_signal |=> $stable(ref_flag))
    else $error("low-reference flag moved mid-conversion");
  AST_STATUS_READ: assert property (i_rd_en && hit(i_addr, `ASEM_ADDR_STATUS) |=>
    o_rd_data == {$past(por_flag), $past(state == ST_READY), 5'h00, $past(ref_flag)})
    else $error("status read wrong");

  CV_POR_CLEAR: cover property (por_flag ##1 !por_flag);
  CV_SHARED_PIN: cover property (o_source_one_pin_select == o_source_two_pin_select &&
    o_excitation_active);
  CV_REF_FAULT: cover property (i_conversion_done_signal ##1 ref_flag);
endmodule

`default_nettype wire

/* File: tb/asem_core_model.sv */
`timescale 1ns/1ns
`default_nettype none

module asem_core_model (
  // Clock
  input wire logic i_clk,
  // Core status toward the block
  output logic o_por_event,
  output logic o_ref_monitor_enable,
  output logic o_ref_below_threshold,
  output logic o_conversion_done_signal,
  output logic [2:0] o_gain_code,
  output logic [1:0] o_amplifier_enable_code
);
  initial begin
    o_por_event = 1'b0;
    o_ref_monitor_enable = 1'b0;
    o_ref_below_threshold = 1'b0;
    o_conversion_done_signal = 1'b0;
    o_gain_code = 3'h0;
    o_amplifier_enable_code = 2'h0;
  end

  // Host keeps gain at 4 or below, code 2
  task automatic set_amp(input logic [2:0] gain, input logic [1:0] en);
    @(posedge i_clk);
    o_gain_code <= (gain > 3'h2) ? 3'h2 : gain;
    o_amplifier_enable_code <= en;
  endtask

  // One conversion; low level dropped on the same edge that raises the done pulse
  task automatic convert(input logic en, input logic low);
    @(posedge i_clk);
    o_ref_monitor_enable <= en;
    o_ref_below_threshold <= low;
    repeat (2) @(posedge i_clk);
    o_ref_below_threshold <= 1'b0;
    o_conversion_done_signal <= 1'b1;
    @(posedge i_clk);
    o_conversion_done_signal <= 1'b0;
  endtask

  task automatic por_pulse;
    @(posedge i_clk);
    o_por_event <= 1'b1;
    @(posedge i_clk);
    o_por_event <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "asem_cfg.svh"

module testbench;
  import asem_pkg::*;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  asem_byte_type i_addr = 8'h00;
  asem_byte_type i_wr_data = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  asem_byte_type o_rd_data;
  logic i_por_event, i_ref_monitor_enable, i_ref_below_threshold, i_conversion_done_signal;
  logic [2:0] i_gain_code;
  logic [1:0] i_amplifier_enable_code;
  asem_nibble_type o_current_magnitude_code, o_source_one_pin_select, o_source_two_pin_select;
  logic o_excitation_active;
  logic [6:0] o_bias_pin_enable;
  logic o_temp_sensor_en, o_analog_supply_reading_en, o_digital_supply_reading_en;
  logic o_midscale_force, o_inputs_disconnect, o_burnout_current_source;
  asem_burnout_type o_burnout_level;
  logic [2:0] o_effective_gain;
  logic [1:0] o_amplifier_enable_code;
  logic o_power_on_reset_flag, o_ready, o_low_reference_flag;
  int n_errors = 0;
  int n_checks = 0;
  asem_byte_type d;
  // Bias settling for a 0.1 uF load at 100 ns per cycle
  localparam int BIAS_SETTLE_CYCLES = 2800;
  // Reference control lives outside this block
  localparam asem_byte_type REF_CTRL_ADDR = 8'h05;

  always #50 i_clk = ~i_clk;

  asem_ctrl #(.STARTUP_CYCLES(8)) u_dut (
    .i_clk, .i_arst_n, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data,
    .i_por_event, .i_ref_monitor_enable, .i_ref_below_threshold, .i_conversion_done_signal,
    .i_gain_code, .i_amplifier_enable_code, .o_current_magnitude_code, .o_excitation_active,
    .o_source_one_pin_select, .o_source_two_pin_select, .o_bias_pin_enable,
    .o_temp_sensor_en, .o_analog_supply_reading_en, .o_digital_supply_reading_en,
    .o_midscale_force, .o_inputs_disconnect, .o_burnout_current_source, .o_burnout_level,
    .o_effective_gain, .o_amplifier_enable_code, .o_power_on_reset_flag, .o_ready,
    .o_low_reference_flag
  );

  asem_core_model u_core (
    .i_clk(i_clk),
    .o_por_event(i_por_event),
    .o_ref_monitor_enable(i_ref_monitor_enable),
    .o_ref_below_threshold(i_ref_below_threshold),
    .o_conversion_done_signal(i_conversion_done_signal),
    .o_gain_code(i_gain_code),
    .o_amplifier_enable_code(i_amplifier_enable_code)
  );

  task automatic chk(input string what, input asem_byte_type exp, input asem_byte_type got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input asem_byte_type a, input asem_byte_type v);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask

  // Read data stands one cycle, then returns to zero
  task automatic chk_reg(input asem_byte_type a, input asem_byte_type exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    @(negedge i_clk);
    chk($sformatf("reg %h", a), exp, o_rd_data);
    @(negedge i_clk);
    chk("read idle", 8'h00, o_rd_data);
  endtask

  task automatic settle;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  function automatic asem_byte_type mon_exp(input logic [2:0] s);
    mon_exp = {s == 3'h2, s == 3'h3, s == 3'h4, s == 3'h1, s inside {3'h2, 3'h3, 3'h4},
               s >= 3'h5, (s >= 3'h5) ? 2'(s - 3'h4) : 2'h0};
  endfunction

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge i_clk);
    chk("por flag in reset", 8'h01, {7'h0, o_power_on_reset_flag});
    chk("ready in reset", 8'h00, {7'h0, o_ready});
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    chk_reg(`ASEM_ADDR_STATUS, 8'h80);
    reg_wr(`ASEM_ADDR_MAG, 8'h0F);
    for (int i = 0; i < 40 && o_ready !== 1'b1; i++) begin
      @(negedge i_clk);
    end
    if (o_ready !== 1'b1) begin
      n_errors++;
      $display("[ERR] ready expected 1 seen %b", o_ready);
      finish_test();
    end
    repeat (2) @(posedge i_clk);
    chk_reg(`ASEM_ADDR_STATUS, 8'hC0);
    chk_reg(`ASEM_ADDR_MAG, `ASEM_RST_MAG);
    chk_reg(`ASEM_ADDR_ROUTE, `ASEM_RST_ROUTE);
    chk_reg(`ASEM_ADDR_BIAS, `ASEM_RST_BIAS);
    chk_reg(`ASEM_ADDR_MON, `ASEM_RST_MON);
    $display("test reset done");

    // Internal reference on before the excitation sources are used
    reg_wr(REF_CTRL_ADDR, 8'h01);
    chk_reg(REF_CTRL_ADDR, 8'h00);
    for (int v = 0; v < 16; v += 5) begin
      reg_wr(`ASEM_ADDR_MAG, {4'h3, 4'(v)});
      settle();
      chk("magnitude", 8'(v), {4'h0, o_current_magnitude_code});
      chk("excitation on", {7'h0, v != 0}, {7'h0, o_excitation_active});
      chk_reg(`ASEM_ADDR_MAG, {4'h3, 4'(v)});
    end
    $display("test magnitude done");

    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 8'h3A : (k == 1) ? 8'h77 : 8'h0F;
      reg_wr(`ASEM_ADDR_ROUTE, d);
      settle();
      chk("source one", {4'h0, d[3:0]}, {4'h0, o_source_one_pin_select});
      chk("source two", {4'h0, d[7:4]}, {4'h0, o_source_two_pin_select});
      chk_reg(`ASEM_ADDR_ROUTE, d);
      d = (k == 0) ? 8'h7F : (k == 1) ? 8'h2A : 8'h55;
      reg_wr(`ASEM_ADDR_BIAS, d);
      settle();
      chk("bias pins", d, {1'b0, o_bias_pin_enable});
    end
    $display("test routing and bias done");

    for (int a = 0; a < 2; a++) begin
      u_core.set_amp(3'h2, 2'(1 - a));
      for (int s = 0; s < 8; s++) begin
        reg_wr(`ASEM_ADDR_MON, {3'(s), 5'h0B});
        settle();
        chk("monitor decode", mon_exp(3'(s)), {o_temp_sensor_en, o_analog_supply_reading_en,
            o_digital_supply_reading_en, o_midscale_force, o_inputs_disconnect,
            o_burnout_current_source,
            o_burnout_level});
        chk("gain", (s == 3 || s == 4) ? 8'h00 : 8'h02, {5'h0, o_effective_gain});
        chk("amp enable", 8'(1 - a), {6'h0, o_amplifier_enable_code});
        chk_reg(`ASEM_ADDR_MON, {3'(s), 5'h0B});
      end
    end
    // Burn-out off again before any precision work
    reg_wr(`ASEM_ADDR_MON, 8'h00);
    $display("test monitor done");

    reg_wr(`ASEM_ADDR_STATUS, 8'hFF);
    chk_reg(`ASEM_ADDR_STATUS, 8'hC0);
    reg_wr(`ASEM_ADDR_STATUS, 8'h7F);
    chk_reg(`ASEM_ADDR_STATUS, 8'h40);
    chk("por flag pin", 8'h00, {7'h0, o_power_on_reset_flag});
    reg_wr(`ASEM_ADDR_STATUS, 8'h80);
    chk_reg(`ASEM_ADDR_STATUS, 8'h40);
    u_core.por_pulse();
    settle();
    chk("por flag pin", 8'h01, {7'h0, o_power_on_reset_flag});
    chk_reg(`ASEM_ADDR_STATUS, 8'hC0);
    reg_wr(`ASEM_ADDR_STATUS, 8'h00);
    // Event and clear in one cycle: the event wins
    fork
      u_core.por_pulse();
      reg_wr(`ASEM_ADDR_STATUS, 8'h00);
    join
    settle();
    chk_reg(`ASEM_ADDR_STATUS, 8'hC0);
    reg_wr(`ASEM_ADDR_STATUS, 8'h00);
    chk_reg(`ASEM_ADDR_STATUS, 8'h40);
    $display("test power-on flag done");

    // Bias pins still enabled; let the bias settle before converting
    repeat (BIAS_SETTLE_CYCLES) @(posedge i_clk);
    u_core.convert(1'b1, 1'b1);
    settle();
    chk("low ref pin", 8'h01, {7'h0, o_low_reference_flag});
    chk_reg(`ASEM_ADDR_STATUS, 8'h41);
    u_core.convert(1'b1, 1'b0);
    settle();
    chk_reg(`ASEM_ADDR_STATUS, 8'h40);
    u_core.convert(1'b0, 1'b1);
    settle();
    chk("low ref pin", 8'h00, {7'h0, o_low_reference_flag});
    $display("test low reference done");

    reg_wr(8'h02, 8'hFF);
    chk_reg(8'h02, 8'h00);
    chk_reg(8'h00, 8'h00);
    chk_reg(`ASEM_ADDR_MAG, 8'h3F);
    $display("test unmapped done");
    finish_test();
  end
endmodule

`default_nettype wire
